// ==== common/irq_dma_pkg.sv ====
// irq and dma routing package: config indexes, reset values, unit control carriers
// assumes a plug-and-play style index/data config port decoded outside this block

package irq_dma_pkg;

  // ----------------------------------------------------------------
  // config space
  // ----------------------------------------------------------------
  localparam logic [7:0] LD_FLOPPY      = 8'h00;
  localparam logic [7:0] LD_PARALLEL    = 8'h03;
  localparam logic [7:0] LD_UART_A      = 8'h04;
  localparam logic [7:0] LD_UART_B      = 8'h05;
  localparam logic [7:0] LD_KEYBOARD    = 8'h07;
  localparam logic [7:0] LD_RUNTIME     = 8'h0a;
  localparam logic [7:0] LD_MGMT_BUS    = 8'h0b;

  localparam logic [7:0] IDX_IRQ_SEL    = 8'h70;
  localparam logic [7:0] IDX_DMA_SEL    = 8'h74;
  localparam logic [7:0] IDX_IRQ8_POL   = 8'hf1;
  localparam int         IRQ8_POL_BIT   = 0;

  localparam logic [7:0] IRQ_SEL_MASK   = 8'h0f;
  localparam logic [7:0] DMA_SEL_MASK   = 8'h07;
  localparam logic [7:0] IRQ_SEL_RST    = 8'h00;
  localparam logic [7:0] FLOPPY_IRQ_RST = 8'h06;
  localparam logic [7:0] FLOPPY_DMA_RST = 8'h02;
  localparam logic [7:0] PAR_DMA_RST    = 8'h04;
  localparam logic [7:0] NO_DMA_RST     = 8'h00;
  localparam logic [7:0] IRQ8_POL_RST   = 8'h00;

  // ----------------------------------------------------------------
  // routing geometry
  // ----------------------------------------------------------------
  localparam int         NUM_LEVELS     = 16;
  localparam int         NUM_DMA        = 4;
  localparam int         NUM_SLOTS      = 6;
  localparam int         DMA_CH_FIRST   = 1;
  localparam int         DMA_CH_LAST    = 3;
  localparam int         SHARED_LEVEL   = 2;
  localparam int         POL_LEVEL      = 8;

  localparam int         SLOT_FLOPPY    = 0;
  localparam int         SLOT_PARALLEL  = 1;
  localparam int         SLOT_UART_A    = 2;
  localparam int         SLOT_UART_B    = 3;
  localparam int         SLOT_KEYBOARD  = 4;
  localparam int         SLOT_MGMT_BUS  = 5;

  // extended parallel mode codes whose irq ignores the irq gate
  localparam logic [2:0] PAR_MODE_FIFO  = 3'h2;
  localparam logic [2:0] PAR_MODE_ECP   = 3'h3;
  localparam logic [2:0] PAR_MODE_TEST  = 3'h6;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic activate;
    logic base_valid;
    logic irq_req;
    logic dma_req;
  } dev_state_t;

  typedef struct packed {
    logic floppy_dma_gate;
    logic powered_down;
  } floppy_ctrl_t;

  typedef struct packed {
    logic       parallel_irq_gate;
    logic       ext_mode;
    logic [2:0] mode_code;
    logic       ext_parallel_service_flag;
    logic       ext_parallel_dma_gate;
  } parallel_ctrl_t;

  typedef struct packed {
    logic [3:0] uart_interrupt_enable_reg;
    logic       modem_aux_output_two;
  } uart_ctrl_t;

  typedef struct packed {
    logic irq_gate;
  } simple_ctrl_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] ldev;
    logic [7:0] index;
    logic [7:0] wdata;
  } cfg_access_t;

endpackage : irq_dma_pkg

// ==== rtl/irq_dma_channel_routing.sv ====
// irq level and dma channel routing for the logical devices of a multi-function i/o chip
// assumes config writes arrive already decoded to logical device, index and data,
// and unit control bits come straight from the owning units' registers
`timescale 1ns/1ps

module irq_dma_channel_routing (
  input  wire logic                              clk_in,
  input  wire logic                              rst_n_in,
  input  wire logic                              ce_in,
  input  wire logic                              soft_rst_in,
  input  wire irq_dma_pkg::cfg_access_t          cfg_in,
  input  wire irq_dma_pkg::dev_state_t           floppy_state_in,
  input  wire irq_dma_pkg::dev_state_t           parallel_state_in,
  input  wire irq_dma_pkg::dev_state_t           uart_a_state_in,
  input  wire irq_dma_pkg::dev_state_t           uart_b_state_in,
  input  wire irq_dma_pkg::dev_state_t           keyboard_state_in,
  input  wire irq_dma_pkg::dev_state_t           mgmt_state_in,
  input  wire irq_dma_pkg::floppy_ctrl_t         floppy_ctrl_in,
  input  wire irq_dma_pkg::parallel_ctrl_t       parallel_ctrl_in,
  input  wire irq_dma_pkg::uart_ctrl_t           uart_a_ctrl_in,
  input  wire irq_dma_pkg::uart_ctrl_t           uart_b_ctrl_in,
  input  wire irq_dma_pkg::simple_ctrl_t         keyboard_ctrl_in,
  input  wire irq_dma_pkg::simple_ctrl_t         mgmt_ctrl_in,
  input  wire logic                              serial_irq_mode_in,
  input  wire logic                              system_mgmt_int_en_in,
  output logic      [irq_dma_pkg::NUM_LEVELS-1:0] irq_level_out,
  output logic      [irq_dma_pkg::NUM_DMA-1:0]   dma_req_out,
  output logic      [7:0]                        cfg_rdata_out
);

  localparam int NS = irq_dma_pkg::NUM_SLOTS;
  localparam int NL = irq_dma_pkg::NUM_LEVELS;
  localparam int ND = irq_dma_pkg::NUM_DMA;

  // ----------------------------------------------------------------
  // per-slot wiring
  // ----------------------------------------------------------------
  irq_dma_pkg::dev_state_t state [NS];
  logic                    slot_hit [NS];
  logic                    unit_irq_en [NS];
  logic                    unit_dma_en [NS];
  logic                    irq_on [NS];
  logic                    dma_on [NS];
  logic [NL-1:0]           slot_irq [NS];
  logic [ND-1:0]           slot_dma [NS];
  logic [7:0]              slot_irq_sel [NS];
  logic [7:0]              slot_dma_sel [NS];
  logic [7:0]              slot_ldev [NS];

  logic                    irq8_polarity;
  logic [NL-1:0]           next_irq_level;
  logic [ND-1:0]           next_dma_req;
  logic [7:0]              next_rdata;
  logic                    par_irq_forced;
  logic                    par_irq_en;
  logic                    par_dma_en;

  assign state[irq_dma_pkg::SLOT_FLOPPY]   = floppy_state_in;
  assign state[irq_dma_pkg::SLOT_PARALLEL] = parallel_state_in;
  assign state[irq_dma_pkg::SLOT_UART_A]   = uart_a_state_in;
  assign state[irq_dma_pkg::SLOT_UART_B]   = uart_b_state_in;
  assign state[irq_dma_pkg::SLOT_KEYBOARD] = keyboard_state_in;
  assign state[irq_dma_pkg::SLOT_MGMT_BUS] = mgmt_state_in;

  assign slot_ldev[irq_dma_pkg::SLOT_FLOPPY]   = irq_dma_pkg::LD_FLOPPY;
  assign slot_ldev[irq_dma_pkg::SLOT_PARALLEL] = irq_dma_pkg::LD_PARALLEL;
  assign slot_ldev[irq_dma_pkg::SLOT_UART_A]   = irq_dma_pkg::LD_UART_A;
  assign slot_ldev[irq_dma_pkg::SLOT_UART_B]   = irq_dma_pkg::LD_UART_B;
  assign slot_ldev[irq_dma_pkg::SLOT_KEYBOARD] = irq_dma_pkg::LD_KEYBOARD;
  assign slot_ldev[irq_dma_pkg::SLOT_MGMT_BUS] = irq_dma_pkg::LD_MGMT_BUS;

  // ----------------------------------------------------------------
  // unit enables
  // ----------------------------------------------------------------
  // floppy: the dma gate of its digital output register covers both irq and dma,
  // and power-down overrides everything the unit asks for
  assign unit_irq_en[irq_dma_pkg::SLOT_FLOPPY] =
      floppy_ctrl_in.floppy_dma_gate && !floppy_ctrl_in.powered_down;
  assign unit_dma_en[irq_dma_pkg::SLOT_FLOPPY] =
      floppy_ctrl_in.floppy_dma_gate && !floppy_ctrl_in.powered_down;

  // parallel: in extended mode some mode codes hold the irq on regardless of the gate
  always_comb begin
    par_irq_forced = 1'b0;
    unique case (parallel_ctrl_in.mode_code)
      irq_dma_pkg::PAR_MODE_FIFO,
      irq_dma_pkg::PAR_MODE_ECP,
      irq_dma_pkg::PAR_MODE_TEST: par_irq_forced = 1'b1;
      default:                    par_irq_forced = 1'b0;
    endcase
  end

  always_comb begin
    if (parallel_ctrl_in.ext_mode) begin
      par_irq_en = (par_irq_forced || parallel_ctrl_in.parallel_irq_gate)
                   && !parallel_ctrl_in.ext_parallel_service_flag;
      par_dma_en = parallel_ctrl_in.ext_parallel_dma_gate;
    end else begin
      par_irq_en = parallel_ctrl_in.parallel_irq_gate;
      // outside extended mode the port has no dma path
      par_dma_en = 1'b0;
    end
  end

  assign unit_irq_en[irq_dma_pkg::SLOT_PARALLEL] = par_irq_en;
  assign unit_dma_en[irq_dma_pkg::SLOT_PARALLEL] = par_dma_en;

  // uarts: any of the four enables plus aux output two; without it the line stays quiet
  assign unit_irq_en[irq_dma_pkg::SLOT_UART_A] =
      (|uart_a_ctrl_in.uart_interrupt_enable_reg) && uart_a_ctrl_in.modem_aux_output_two;
  assign unit_irq_en[irq_dma_pkg::SLOT_UART_B] =
      (|uart_b_ctrl_in.uart_interrupt_enable_reg) && uart_b_ctrl_in.modem_aux_output_two;
  assign unit_dma_en[irq_dma_pkg::SLOT_UART_A] = 1'b0;
  assign unit_dma_en[irq_dma_pkg::SLOT_UART_B] = 1'b0;

  assign unit_irq_en[irq_dma_pkg::SLOT_KEYBOARD] = keyboard_ctrl_in.irq_gate;
  assign unit_dma_en[irq_dma_pkg::SLOT_KEYBOARD] = 1'b0;

  assign unit_irq_en[irq_dma_pkg::SLOT_MGMT_BUS] = mgmt_ctrl_in.irq_gate;
  assign unit_dma_en[irq_dma_pkg::SLOT_MGMT_BUS] = 1'b0;

  // ----------------------------------------------------------------
  // slots
  // ----------------------------------------------------------------
  for (genvar s = 0; s < NS; s++) begin : g_slot
    localparam logic [7:0] IRQ_R = (s == irq_dma_pkg::SLOT_FLOPPY) ?
                                   irq_dma_pkg::FLOPPY_IRQ_RST : irq_dma_pkg::IRQ_SEL_RST;
    localparam logic [7:0] DMA_R = (s == irq_dma_pkg::SLOT_FLOPPY)   ? irq_dma_pkg::FLOPPY_DMA_RST :
                                   (s == irq_dma_pkg::SLOT_PARALLEL) ? irq_dma_pkg::PAR_DMA_RST :
                                                                       irq_dma_pkg::NO_DMA_RST;
    localparam bit         HAS_D = (s == irq_dma_pkg::SLOT_FLOPPY) ||
                                   (s == irq_dma_pkg::SLOT_PARALLEL);

    assign slot_hit[s] = cfg_in.wr && (cfg_in.ldev == slot_ldev[s]);

    // a deactivated unit or one with a bad base address never drives a line
    assign irq_on[s] = state[s].activate && state[s].base_valid
                       && unit_irq_en[s] && state[s].irq_req;
    assign dma_on[s] = state[s].activate && state[s].base_valid
                       && unit_dma_en[s] && state[s].dma_req;

    ldev_route_slot #(
      .IRQ_RST (IRQ_R),
      .DMA_RST (DMA_R),
      .HAS_DMA (HAS_D)
    ) u_slot (
      .clk_in        (clk_in),
      .rst_n_in      (rst_n_in),
      .ce_in         (ce_in),
      .soft_rst_in   (soft_rst_in),
      .wr_in         (slot_hit[s]),
      .index_in      (cfg_in.index),
      .wdata_in      (cfg_in.wdata),
      .irq_on_in     (irq_on[s]),
      .dma_on_in     (dma_on[s]),
      .irq_lines_out (slot_irq[s]),
      .dma_lines_out (slot_dma[s]),
      .irq_sel_out   (slot_irq_sel[s]),
      .dma_sel_out   (slot_dma_sel[s])
    );
  end

  // ----------------------------------------------------------------
  // level 8 polarity, vendor range: only hard reset clears it
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq8_polarity <= irq_dma_pkg::IRQ8_POL_RST[irq_dma_pkg::IRQ8_POL_BIT];
    end else if (ce_in) begin
      if (cfg_in.wr && cfg_in.ldev == irq_dma_pkg::LD_RUNTIME
          && cfg_in.index == irq_dma_pkg::IDX_IRQ8_POL) begin
        irq8_polarity <= cfg_in.wdata[irq_dma_pkg::IRQ8_POL_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // merge
  // ----------------------------------------------------------------
  // a level nobody selects collects no term and so rests low, save level 8 while its polarity bit is set; the parallel unit's
  // extended-mode irq request is blocked while its service flag is set
  always_comb begin
    next_irq_level = '0;
    next_dma_req   = '0;
    for (int s = 0; s < NS; s++) begin
      next_irq_level = next_irq_level | slot_irq[s];
      next_dma_req   = next_dma_req | slot_dma[s];
    end
    // level 2 is lost to the low-active mgmt interrupt unless serialised
    if (system_mgmt_int_en_in && !serial_irq_mode_in) begin
      next_irq_level[irq_dma_pkg::SHARED_LEVEL] = 1'b0;
    end
    next_irq_level[irq_dma_pkg::POL_LEVEL] =
        next_irq_level[irq_dma_pkg::POL_LEVEL] ^ irq8_polarity;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_level_out <= '0;
    end else if (ce_in) begin
      irq_level_out <= next_irq_level;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dma_req_out <= '0;
    end else if (ce_in) begin
      dma_req_out <= next_dma_req;
    end
  end

  // ----------------------------------------------------------------
  // readback, one cycle after the read strobe
  // ----------------------------------------------------------------
  always_comb begin
    next_rdata = 8'h00;
    if (cfg_in.ldev == irq_dma_pkg::LD_RUNTIME
        && cfg_in.index == irq_dma_pkg::IDX_IRQ8_POL) begin
      next_rdata[irq_dma_pkg::IRQ8_POL_BIT] = irq8_polarity;
    end
    for (int s = 0; s < NS; s++) begin
      if (cfg_in.ldev == slot_ldev[s]) begin
        if (cfg_in.index == irq_dma_pkg::IDX_IRQ_SEL) begin
          next_rdata = slot_irq_sel[s];
        end else if (cfg_in.index == irq_dma_pkg::IDX_DMA_SEL) begin
          next_rdata = slot_dma_sel[s];
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cfg_rdata_out <= 8'h00;
    end else if (ce_in) begin
      cfg_rdata_out <= cfg_in.rd ? next_rdata : 8'h00;
    end
  end

endmodule : irq_dma_channel_routing

// ==== rtl/ldev_route_slot.sv ====
// one logical device: its irq and dma select registers and their decode
// assumes gating enables are already combined by the parent
`timescale 1ns/1ps

module ldev_route_slot #(
  parameter logic [7:0] IRQ_RST = irq_dma_pkg::IRQ_SEL_RST,
  parameter logic [7:0] DMA_RST = irq_dma_pkg::NO_DMA_RST,
  parameter bit         HAS_DMA = 1'b0
) (
  input  wire logic                                clk_in,
  input  wire logic                                rst_n_in,
  input  wire logic                                ce_in,
  input  wire logic                                soft_rst_in,
  input  wire logic                                wr_in,
  input  wire logic [7:0]                          index_in,
  input  wire logic [7:0]                          wdata_in,
  input  wire logic                                irq_on_in,
  input  wire logic                                dma_on_in,
  output logic      [irq_dma_pkg::NUM_LEVELS-1:0]  irq_lines_out,
  output logic      [irq_dma_pkg::NUM_DMA-1:0]     dma_lines_out,
  output logic      [7:0]                          irq_sel_out,
  output logic      [7:0]                          dma_sel_out
);

  logic [7:0] irq_sel;
  logic [7:0] dma_sel;

  // ----------------------------------------------------------------
  // select registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_sel <= IRQ_RST;
    end else if (ce_in) begin
      if (soft_rst_in) begin
        irq_sel <= IRQ_RST;
      end else if (wr_in && index_in == irq_dma_pkg::IDX_IRQ_SEL) begin
        irq_sel <= wdata_in & irq_dma_pkg::IRQ_SEL_MASK;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dma_sel <= DMA_RST;
    end else if (ce_in) begin
      if (soft_rst_in) begin
        dma_sel <= DMA_RST;
      end else if (HAS_DMA && wr_in && index_in == irq_dma_pkg::IDX_DMA_SEL) begin
        dma_sel <= wdata_in & irq_dma_pkg::DMA_SEL_MASK;
      end
    end
  end

  assign irq_sel_out = irq_sel;
  assign dma_sel_out = HAS_DMA ? dma_sel : 8'h00;

  // ----------------------------------------------------------------
  // decode: zero selects nothing, reserved dma codes select nothing
  // ----------------------------------------------------------------
  assign irq_lines_out[0] = 1'b0;
  assign dma_lines_out[0] = 1'b0;

  for (genvar lv = 1; lv < irq_dma_pkg::NUM_LEVELS; lv++) begin : g_irq
    assign irq_lines_out[lv] = irq_on_in && (irq_sel == 8'(lv));
  end

  for (genvar ch = irq_dma_pkg::DMA_CH_FIRST; ch <= irq_dma_pkg::DMA_CH_LAST; ch++) begin : g_dma
    assign dma_lines_out[ch] = HAS_DMA && dma_on_in && (dma_sel == 8'(ch));
  end

endmodule : ldev_route_slot

// ==== verification/host_req_model.sv ====
// host request sampler: counts rising edges seen on the routed request levels
// assumes registered request levels in the same clock domain as the sampler
`timescale 1ns/1ps

module host_req_model (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [15:0] irq_level_in,
  output logic      [31:0] irq_edges_out
);
  logic [15:0] last_level;

  // the host latches on the low-to-high change only, so a held level counts once
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      last_level    <= 16'h0000;
      irq_edges_out <= 32'h0000_0000;
    end else begin
      last_level    <= irq_level_in;
      irq_edges_out <= irq_edges_out + 32'($countones(irq_level_in & ~last_level));
    end
  end
endmodule : host_req_model

// ==== verification/irq_dma_channel_routing_tb.sv ====
// random unit states over random selects, with reset, soft reset and polarity corners
// assumes the host sampler beside the outputs and a 200 MHz clock
`timescale 1ns/1ps

module irq_dma_channel_routing_tb;
  logic                        clk_in, rst_n_in, ce_in, soft_rst_in, smi_en, serial, pol;
  irq_dma_pkg::cfg_access_t    cfg;
  irq_dma_pkg::dev_state_t     st [6];
  irq_dma_pkg::floppy_ctrl_t   fc;
  irq_dma_pkg::parallel_ctrl_t pc;
  irq_dma_pkg::uart_ctrl_t     ua, ub;
  irq_dma_pkg::simple_ctrl_t   kc, mc;
  logic [15:0]                 irq_level_out, exp_i, prev_i;
  logic [3:0]                  dma_req_out, exp_d;
  logic [7:0]                  cfg_rdata_out, isel [6], dsel [2];
  logic [7:0]                  ld [6] = '{8'h00, 8'h03, 8'h04, 8'h05, 8'h07, 8'h0b};
  logic [31:0]                 edges, base, host_edges;
  int                          fail_count = 0, checks_done = 0, seed = 92858, cycles = 0;

  irq_dma_channel_routing dut (.clk_in, .rst_n_in, .ce_in, .soft_rst_in, .cfg_in(cfg),
    .floppy_state_in(st[0]), .parallel_state_in(st[1]), .uart_a_state_in(st[2]),
    .uart_b_state_in(st[3]), .keyboard_state_in(st[4]), .mgmt_state_in(st[5]),
    .floppy_ctrl_in(fc), .parallel_ctrl_in(pc), .uart_a_ctrl_in(ua), .uart_b_ctrl_in(ub),
    .keyboard_ctrl_in(kc), .mgmt_ctrl_in(mc), .serial_irq_mode_in(serial),
    .system_mgmt_int_en_in(smi_en), .irq_level_out, .dma_req_out, .cfg_rdata_out);
  host_req_model host (.clk_in, .rst_n_in, .irq_level_in(irq_level_out),
    .irq_edges_out(host_edges));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] l, x, d);
    @(posedge clk_in) cfg <= '{1'b1, 1'b0, l, x, d};
    @(posedge clk_in) cfg <= '0;
  endtask : wr

  task automatic rdc(input logic [7:0] l, x, e);
    @(posedge clk_in) cfg <= '{1'b0, 1'b1, l, x, 8'h00};
    @(posedge clk_in) cfg <= '0;
    #1 chk(cfg_rdata_out, e);
  endtask : rdc

  function automatic void route(output logic [15:0] ei, output logic [3:0] ed);
    logic [5:0] en;
    ei = '0;
    ed = '0;
    en[0] = fc.floppy_dma_gate & ~fc.powered_down;
    en[1] = pc.ext_mode ? (pc.parallel_irq_gate | (pc.mode_code inside {3'h2, 3'h3, 3'h6}))
            & ~pc.ext_parallel_service_flag : pc.parallel_irq_gate;
    en[2] = |ua.uart_interrupt_enable_reg & ua.modem_aux_output_two;
    en[3] = |ub.uart_interrupt_enable_reg & ub.modem_aux_output_two;
    en[4] = kc.irq_gate;
    en[5] = mc.irq_gate;
    for (int i = 0; i < 6; i++) begin
      if (st[i].activate & st[i].base_valid & st[i].irq_req & en[i]) ei[isel[i][3:0]] = 1'b1;
      if (i < 2 && (dsel[i][2:0] inside {[3'h1:3'h3]}) && st[i].activate & st[i].base_valid
          & st[i].dma_req & (i == 0 ? en[0] : pc.ext_mode & pc.ext_parallel_dma_gate))
        ed[dsel[i][1:0]] = 1'b1;
    end
    ei[0] = 1'b0;
    if (smi_en & ~serial) ei[2] = 1'b0;
    ei[8] = ei[8] ^ pol;
  endfunction : route

  task automatic vec();
    @(posedge clk_in) begin
      for (int i = 0; i < 6; i++) st[i] <= 4'($random(seed) | $random(seed));
      fc <= 2'($random(seed));
      pc <= 7'($random(seed));
      ua <= 5'($random(seed));
      ub <= 5'($random(seed));
      {kc, mc, smi_en, serial} <= 4'($random(seed));
    end
    @(posedge clk_in) #1;
    route(exp_i, exp_d);
    chk(irq_level_out, exp_i);
    chk(dma_req_out, exp_d);
    edges += $countones(exp_i & ~prev_i);
    prev_i = exp_i;
  endtask : vec

  task automatic round(input int r);
    logic [7:0] q;
    @(posedge clk_in) for (int i = 0; i < 6; i++) st[i] <= '0;
    // a third edge lets the sampler count any idle-level rise before the baseline is taken
    repeat (3) @(posedge clk_in);
    for (int i = 0; i < 6 && r < 3; i++) begin
      q = (r == 0) ? 8'hf2 : 8'($random(seed));
      isel[i] = q & 8'h0f;
      wr(ld[i], 8'h70, q);
      rdc(ld[i], 8'h70, isel[i]);
      q = (r == 0) ? 8'hf8 : 8'($random(seed));
      if (i < 2) dsel[i] = q & 8'h07;
      if (i < 2) wr(ld[i], 8'h74, q);
      if (i < 2) rdc(ld[i], 8'h74, dsel[i]);
    end
    base = host_edges;
    prev_i = {7'h00, pol, 8'h00};
    edges = 0;
    repeat (100) vec();
    @(posedge clk_in) #1 chk(host_edges - base, edges);
  endtask : round

  // ----------------------------------------------------------------
  // clock, timeout and main sequence
  // ----------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      close_out();
    end
  end

  initial begin
    {rst_n_in, soft_rst_in, smi_en, serial, pol, cfg, fc, pc, ua, ub, kc, mc} = '0;
    ce_in = 1'b1;
    for (int i = 0; i < 6; i++) st[i] = '0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rdc(8'h00, 8'h70, 8'h06);
    rdc(8'h00, 8'h74, 8'h02);
    rdc(8'h03, 8'h74, 8'h04);
    rdc(8'h04, 8'h70, 8'h00);
    rdc(8'h09, 8'h70, 8'h00);
    wr(8'h04, 8'h74, 8'h01);
    rdc(8'h04, 8'h74, 8'h00);
    round(0);
    round(1);
    // a write while the clock enable is low must leave the select untouched
    @(posedge clk_in) ce_in <= 1'b0;
    wr(8'h00, 8'h70, 8'h0b);
    @(posedge clk_in) ce_in <= 1'b1;
    rdc(8'h00, 8'h70, isel[0]);
    wr(8'h0a, 8'hf1, 8'h01);
    pol = 1'b1;
    rdc(8'h0a, 8'hf1, 8'h01);
    round(2);
    @(posedge clk_in) soft_rst_in <= 1'b1;
    @(posedge clk_in) soft_rst_in <= 1'b0;
    rdc(8'h00, 8'h70, 8'h06);
    rdc(8'h03, 8'h74, 8'h04);
    rdc(8'h0a, 8'hf1, 8'h01);
    isel = '{8'h06, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    dsel = '{8'h02, 8'h04};
    round(3);
    close_out();
  end
endmodule : irq_dma_channel_routing_tb

// ==== verification/irq_dma_routing_assertions.sv ====
// checker for irq and dma routing: gating, level decode and config readback
// assumes one clock domain; bound onto the routing top by port name
`timescale 1ns/1ps

module irq_dma_routing_assertions (
  input wire logic                         clk_in,
  input wire logic                         rst_n_in,
  input wire logic                         ce_in,
  input wire logic                         soft_rst_in,
  input wire irq_dma_pkg::cfg_access_t     cfg_in,
  input wire irq_dma_pkg::dev_state_t      floppy_state_in,
  input wire irq_dma_pkg::dev_state_t      parallel_state_in,
  input wire irq_dma_pkg::dev_state_t      uart_a_state_in,
  input wire irq_dma_pkg::dev_state_t      uart_b_state_in,
  input wire irq_dma_pkg::dev_state_t      keyboard_state_in,
  input wire irq_dma_pkg::dev_state_t      mgmt_state_in,
  input wire irq_dma_pkg::floppy_ctrl_t    floppy_ctrl_in,
  input wire irq_dma_pkg::parallel_ctrl_t  parallel_ctrl_in,
  input wire logic                         serial_irq_mode_in,
  input wire logic                         system_mgmt_int_en_in,
  input wire logic [15:0]                  irq_level_out,
  input wire logic [3:0]                   dma_req_out,
  input wire logic [7:0]                   cfg_rdata_out
);
  irq_dma_pkg::parallel_ctrl_t p;
  irq_dma_pkg::dev_state_t     f;
  logic                        fl_en, any_irq, any_dma, none_live;

  function automatic logic up(input irq_dma_pkg::dev_state_t s);
    return s.activate & s.base_valid;
  endfunction : up

  // uart, keyboard and mgmt enables are unseen here, so their requests count as enabled
  always_comb begin
    p = parallel_ctrl_in;
    f = floppy_state_in;
    fl_en = floppy_ctrl_in.floppy_dma_gate & ~floppy_ctrl_in.powered_down;
    any_irq = up(f) & f.irq_req & fl_en
      | up(parallel_state_in) & parallel_state_in.irq_req & ~(p.ext_mode & p.ext_parallel_service_flag)
        & (p.parallel_irq_gate | p.ext_mode & (p.mode_code inside {3'h2, 3'h3, 3'h6}))
      | up(uart_a_state_in) & uart_a_state_in.irq_req | up(uart_b_state_in) & uart_b_state_in.irq_req
      | up(keyboard_state_in) & keyboard_state_in.irq_req | up(mgmt_state_in) & mgmt_state_in.irq_req;
    any_dma = up(f) & f.dma_req & fl_en
      | up(parallel_state_in) & parallel_state_in.dma_req & p.ext_mode & p.ext_parallel_dma_gate;
    none_live = ~(up(f) | up(parallel_state_in) | up(uart_a_state_in) | up(uart_b_state_in)
      | up(keyboard_state_in) | up(mgmt_state_in));
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence irq_sel_wr;
    ce_in && cfg_in.wr && !soft_rst_in && cfg_in.index == 8'h70;
  endsequence
  sequence quiet_rd;
    ce_in && !cfg_in.wr && !soft_rst_in ##1 ce_in && cfg_in.rd && !cfg_in.wr && !soft_rst_in
    && cfg_in.index == 8'h70 && cfg_in.ldev == $past(cfg_in.ldev, 2)
    && (cfg_in.ldev inside {8'h00, 8'h03, 8'h04, 8'h05, 8'h07, 8'h0b});
  endsequence
  sequence soft_then_rd;
    ce_in && soft_rst_in ##1 ce_in && !soft_rst_in && !cfg_in.wr ##1 ce_in && !soft_rst_in
    && !cfg_in.wr && cfg_in.rd && cfg_in.ldev == 8'h00 && cfg_in.index == 8'h70;
  endsequence

  lvl0_zero_a: assert property (!irq_level_out[0] && !dma_req_out[0])
    else $error("level 0 or channel 0 driven");
  irq_gating_a: assert property ($past(ce_in) && !$past(any_irq) |->
    (irq_level_out & 16'hfeff) == 16'h0000) else $error("irq with no enabled unit");
  dma_gating_a: assert property ($past(ce_in) && !$past(any_dma) |->
    dma_req_out == 4'h0) else $error("dma with no enabled unit");
  idle_lines_a: assert property ($past(ce_in) && $past(none_live) |->
    (irq_level_out & 16'hfeff) == 16'h0000 && dma_req_out == 4'h0) else $error("idle line active");
  shared_level_a: assert property ($past(ce_in && system_mgmt_int_en_in && !serial_irq_mode_in)
    |-> !irq_level_out[2]) else $error("level 2 driven while mgmt owns it");
  dma_reserved_a: assert property (ce_in && cfg_in.rd && cfg_in.index == 8'h74
    |=> cfg_rdata_out[7:3] == 5'h00) else $error("dma select upper bits set");
  wr_readback_a: assert property (irq_sel_wr ##1 quiet_rd
    |=> cfg_rdata_out == ($past(cfg_in.wdata, 3) & 8'h0f)) else $error("irq select readback");
  soft_default_a: assert property (soft_then_rd |=> cfg_rdata_out == 8'h06)
    else $error("floppy irq select not restored");
endmodule : irq_dma_routing_assertions

bind irq_dma_channel_routing irq_dma_routing_assertions chk_i (.*);
